// ---- core/mrl_pkg.sv ----
package mrl_pkg;
   // Register offsets on the device's internal register port.
   localparam logic [7:0] MRL_OFS_VOLT_CH3 = 8'h23;
   localparam logic [7:0] MRL_OFS_VOLT_CH4 = 8'h24;
   localparam logic [7:0] MRL_OFS_VOLT_CH5 = 8'h25;
   localparam logic [7:0] MRL_OFS_VOLT_CH6 = 8'h26;
   localparam logic [7:0] MRL_OFS_THERMAL = 8'h27;
   localparam logic [7:0] MRL_OFS_FAN_A = 8'h28;
   localparam logic [7:0] MRL_OFS_FAN_B = 8'h29;
   localparam logic [7:0] MRL_OFS_CH0_UPPER = 8'h2a;
   localparam logic [7:0] MRL_OFS_CH0_LOWER = 8'h2b;
   localparam logic [7:0] MRL_OFS_CH1_UPPER = 8'h2c;
   // Field positions and widths.
   localparam int MRL_VOLT_LSB = 6;
   localparam int MRL_VOLT_W = 10;
   localparam int MRL_TEMP_LSB = 4;
   localparam int MRL_TEMP_W = 12;
   // Reset values.
   localparam logic [15:0] MRL_RST_RESULT = 16'h0000;
   localparam logic [7:0] MRL_RST_BYTE = 8'h00;

   // One register port access.
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [15:0] wdata;
   } mrl_req_t;

   // Fresh conversion results from the converter.
   typedef struct packed {
      logic [3:0] volt_valid;
      logic [MRL_VOLT_W-1:0] volt_ch3_value;
      logic [MRL_VOLT_W-1:0] volt_ch4_value;
      logic [MRL_VOLT_W-1:0] volt_ch5_value;
      logic [MRL_VOLT_W-1:0] volt_ch6_value;
      logic temp_valid;
      logic [MRL_TEMP_W-1:0] temp_value;
   } mrl_conv_t;
endpackage : mrl_pkg

// ---- core/mrl_regs.sv ----
module mrl_regs
   import mrl_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic reset,
   // Register port.
   input wire mrl_req_t req,
   output logic [15:0] rdata,
   output logic rvalid,
   // Converter results.
   input wire mrl_conv_t conv,
   // Tachometer pins.
   input wire logic fan_a_pulse_input,
   input wire logic fan_b_pulse_input,
   // Bounds for the comparison logic.
   output logic [7:0] volt_ch0_upper,
   output logic [7:0] volt_ch0_lower,
   output logic [7:0] volt_ch1_upper
);
   logic [MRL_VOLT_W-1:0] volt_r [4];
   logic [MRL_TEMP_W-1:0] temp_r;
   logic [7:0] fan_a_count_value;
   logic [7:0] fan_b_count_value;
   logic [2:0] tach_a_sync_r;
   logic [2:0] tach_b_sync_r;
   logic [7:0] ch0_upper_r;
   logic [7:0] ch0_lower_r;
   logic [7:0] ch1_upper_r;
   logic [15:0] rdata_nxt;
   logic [MRL_VOLT_W-1:0] volt_in [4];

   assign volt_in[0] = conv.volt_ch3_value;
   assign volt_in[1] = conv.volt_ch4_value;
   assign volt_in[2] = conv.volt_ch5_value;
   assign volt_in[3] = conv.volt_ch6_value;

   // Voltage results follow the converter only; the port cannot write them.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < 4; i++) volt_r[i] <= '0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (conv.volt_valid[i]) volt_r[i] <= volt_in[i];
         end
      end
   end

   // Temperature result follows the converter only.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         temp_r <= '0;
      end else if (conv.temp_valid) begin
         temp_r <= conv.temp_value;
      end
   end

   // Tach pins pass two flip-flops; the third stage feeds the edge detect.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         tach_a_sync_r <= '0;
         tach_b_sync_r <= '0;
      end else begin
         tach_a_sync_r <= {tach_a_sync_r[1:0], fan_a_pulse_input};
         tach_b_sync_r <= {tach_b_sync_r[1:0], fan_b_pulse_input};
      end
   end

   // Each rising tach edge adds one to its own count, wrapping at eight bits.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         fan_a_count_value <= MRL_RST_BYTE;
         fan_b_count_value <= MRL_RST_BYTE;
      end else begin
         if (tach_a_sync_r[1] && !tach_a_sync_r[2]) begin
            fan_a_count_value <= fan_a_count_value + 8'h01;
         end
         if (tach_b_sync_r[1] && !tach_b_sync_r[2]) begin
            fan_b_count_value <= fan_b_count_value + 8'h01;
         end
      end
   end

   // Bound registers take the low byte of a write.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ch0_upper_r <= MRL_RST_BYTE;
         ch1_upper_r <= MRL_RST_BYTE;
         ch0_lower_r <= MRL_RST_BYTE;
      end else if (req.wr) begin
         unique case (req.addr)
            MRL_OFS_CH0_UPPER: ch0_upper_r <= req.wdata[7:0];
            MRL_OFS_CH1_UPPER: ch1_upper_r <= req.wdata[7:0];
            MRL_OFS_CH0_LOWER: ch0_lower_r <= req.wdata[7:0];
            default: ;
         endcase
      end
   end

   // Read mux; low bits below data fields and unmapped offsets read zero.
   always_comb begin
      rdata_nxt = MRL_RST_RESULT;
      unique case (req.addr)
         MRL_OFS_VOLT_CH3: rdata_nxt = {volt_r[0], 6'h00};
         MRL_OFS_VOLT_CH4: rdata_nxt = {volt_r[1], 6'h00};
         MRL_OFS_VOLT_CH5: rdata_nxt = {volt_r[2], 6'h00};
         MRL_OFS_VOLT_CH6: rdata_nxt = {volt_r[3], 6'h00};
         MRL_OFS_THERMAL: rdata_nxt = {temp_r, 4'h0};
         MRL_OFS_FAN_A: rdata_nxt = {8'h00, fan_a_count_value};
         MRL_OFS_FAN_B: rdata_nxt = {8'h00, fan_b_count_value};
         MRL_OFS_CH0_UPPER: rdata_nxt = {8'h00, ch0_upper_r};
         MRL_OFS_CH0_LOWER: rdata_nxt = {8'h00, ch0_lower_r};
         MRL_OFS_CH1_UPPER: rdata_nxt = {8'h00, ch1_upper_r};
         default: rdata_nxt = MRL_RST_RESULT;
      endcase
   end

   // Read data is registered one cycle after the read strobe.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rdata <= MRL_RST_RESULT;
         rvalid <= 1'b0;
      end else begin
         rvalid <= req.rd;
         if (req.rd) rdata <= rdata_nxt;
      end
   end

   assign volt_ch0_upper = ch0_upper_r;
   assign volt_ch0_lower = ch0_lower_r;
   assign volt_ch1_upper = ch1_upper_r;
endmodule : mrl_regs

// ---- tb/mrl_regs_properties.sv ----
module mrl_regs_properties
   import mrl_pkg::*;
(
   // Clock, reset and register port.
   input wire logic ref_clk, input wire logic reset, input wire mrl_req_t req,
   input wire logic [15:0] rdata, input wire logic rvalid,
   // Bound outputs.
   input wire logic [7:0] volt_ch0_upper, input wire logic [7:0] volt_ch0_lower,
   input wire logic [7:0] volt_ch1_upper
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   logic [7:0] wbyte;
   // Low byte of write data, kept so that a bound can be compared with it.
   assign wbyte = req.wdata[7:0];
   // Read alignment, bound updates and ignored writes.
   property p_volt; req.rd && req.addr inside {[8'h23:8'h26]} |=> rvalid && rdata[5:0] == 6'h00;
   endproperty
   a_volt: assert property (p_volt) else $error("voltage read misaligned");
   property p_temp; req.rd && req.addr == 8'h27 |=> rvalid && rdata[3:0] == 4'h0; endproperty
   a_temp: assert property (p_temp) else $error("temperature read misaligned");
   property p_fan; req.rd && req.addr inside {8'h28, 8'h29} |=> rdata[15:8] == 8'h00; endproperty
   a_fan: assert property (p_fan) else $error("fan count too wide");
   property p_upper; req.wr && req.addr == 8'h2a |=> volt_ch0_upper == $past(wbyte); endproperty
   a_upper: assert property (p_upper) else $error("upper bound not written");
   property p_lower; req.wr && req.addr == 8'h2b |=> volt_ch0_lower == $past(wbyte); endproperty
   a_lower: assert property (p_lower) else $error("lower bound not written");
   property p_ro; req.wr && req.addr < 8'h2a |=> $stable(volt_ch0_upper) && $stable(volt_ch0_lower)
      && $stable(volt_ch1_upper); endproperty
   a_ro: assert property (p_ro) else $error("read-only write changed a bound");
endmodule : mrl_regs_properties

bind mrl_regs mrl_regs_properties chk_u (.ref_clk(ref_clk), .reset(reset), .req(req),
   .rdata(rdata), .rvalid(rvalid), .volt_ch0_upper(volt_ch0_upper),
   .volt_ch0_lower(volt_ch0_lower), .volt_ch1_upper(volt_ch1_upper));

// ---- tb/tb_mrl_regs.sv ----
module tb_mrl_regs;
   timeunit 1ns;
   timeprecision 1ps;
   import mrl_pkg::*;
   logic ref_clk = 1'b0, reset = 1'b1, fa = 1'b0, fb = 1'b0, rvalid;
   logic [7:0] up0, lo0, up1;
   logic [15:0] rdata, d, exp_r [8'h23:8'h2c];
   logic [7:0] a;
   mrl_req_t req = '0;
   mrl_conv_t conv = '0;
   int n_errors = 0, comparisons = 0, cycles = 0, na, seed = 32'h4167;
   mrl_regs dut_u (.ref_clk(ref_clk), .reset(reset), .req(req), .rdata(rdata), .rvalid(rvalid),
      .conv(conv), .fan_a_pulse_input(fa), .fan_b_pulse_input(fb), .volt_ch0_upper(up0),
      .volt_ch0_lower(lo0), .volt_ch1_upper(up1));
   // Clock generation and hang guard.
   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         end_sim();
      end
   end
   // Places a raw value where a read at this offset shows it.
   function automatic logic [15:0] place(logic [7:0] ad, logic [15:0] v);
      if (ad <= 8'h26) return {v[9:0], 6'h00};
      if (ad == 8'h27) return {v[11:0], 4'h0};
      return {8'h00, v[7:0]};
   endfunction : place
   task automatic chk(string what, logic [15:0] e, logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   // One read; the answer stands one cycle after the strobe.
   task automatic rd(logic [7:0] ad, logic [15:0] e);
      @(negedge ref_clk);
      req.rd = 1'b1;
      req.addr = ad;
      @(negedge ref_clk);
      req.rd = 1'b0;
      chk("rvalid", 16'h0001, {15'h0000, rvalid});
      chk("rdata", e, rdata);
   endtask : rd
   task automatic wr(logic [7:0] ad, logic [15:0] v);
      @(negedge ref_clk);
      req.wr = 1'b1;
      req.addr = ad;
      req.wdata = v;
      @(negedge ref_clk);
      req.wr = 1'b0;
   endtask : wr
   task automatic end_sim();
      $display("n_errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim
   // Reset values, random loads and writes, then tach counting with wrap.
   initial begin
      repeat (2) @(negedge ref_clk);
      reset = 1'b0;
      for (int i = 'h23; i <= 'h2c; i++) exp_r[i] = 16'h0000;
      rd(8'h22, 16'h0000);
      repeat (20) begin
         @(negedge ref_clk);
         conv = 57'({$random(seed), $random(seed)});
         if (conv.volt_valid[0]) exp_r[8'h23] = place(8'h23, 16'(conv.volt_ch3_value));
         if (conv.volt_valid[1]) exp_r[8'h24] = place(8'h24, 16'(conv.volt_ch4_value));
         if (conv.volt_valid[2]) exp_r[8'h25] = place(8'h25, 16'(conv.volt_ch5_value));
         if (conv.volt_valid[3]) exp_r[8'h26] = place(8'h26, 16'(conv.volt_ch6_value));
         if (conv.temp_valid) exp_r[8'h27] = place(8'h27, 16'(conv.temp_value));
         @(negedge ref_clk);
         conv = '0;
         a = 8'h23 + 8'($unsigned($random(seed)) % 10);
         d = 16'($random(seed));
         wr(a, d);
         if (a >= 8'h2a) exp_r[a] = place(a, d);
         chk("ch0_upper", exp_r[8'h2a], {8'h00, up0});
         chk("ch0_lower", exp_r[8'h2b], {8'h00, lo0});
         chk("ch1_upper", exp_r[8'h2c], {8'h00, up1});
         for (int i = 'h23; i <= 'h2c; i++) rd(8'(i), exp_r[i]);
      end
      na = $unsigned($random(seed)) % 64;
      for (int i = 0; i < 257; i++) begin
         @(negedge ref_clk);
         fa = (i < na);
         fb = 1'b1;
         @(negedge ref_clk);
         fa = 1'b0;
         fb = 1'b0;
      end
      repeat (4) @(negedge ref_clk);
      rd(8'h28, 16'(na));
      rd(8'h29, 16'h0001);
      end_sim();
   end
endmodule : tb_mrl_regs
